// *** common/sbch_regs.vh ***
// constants for the serial boot command handler
`ifndef SBCH_REGS_VH
`define SBCH_REGS_VH
`define SBCH_ST_SUCCESS      6'h00
`define SBCH_ST_INVALID_CMD  6'h01
`define SBCH_ST_SRC_MISAL    6'h02
`define SBCH_ST_DST_MISAL    6'h03
`define SBCH_ST_SRC_UNMAP    6'h04
`define SBCH_ST_DST_UNMAP    6'h05
`define SBCH_ST_COUNT        6'h06
`define SBCH_ST_BAD_RANGE    6'h07
`define SBCH_ST_NOT_BLANK    6'h08
`define SBCH_ST_NOT_PREP     6'h09
`define SBCH_ST_MISMATCH     6'h0A
`define SBCH_ST_BUSY         6'h0B
`define SBCH_ST_PARAM        6'h0C
`define SBCH_ST_ADDR_MISAL   6'h0D
`define SBCH_ST_ADDR_UNMAP   6'h0E
`define SBCH_ST_LOCKED       6'h0F
`define SBCH_ST_BAD_KEY      6'h10
`define SBCH_ST_BAD_BAUD     6'h11
`define SBCH_ST_BAD_STOP     6'h12
`define SBCH_ST_GUARDED      6'h13
`define SBCH_ST_IMG_CSUM     6'h15
`define SBCH_ST_OSC_OFF      6'h17
`define SBCH_ST_FLASH_OFF    6'h18
`define SBCH_ST_FLASH_NOCLK  6'h1B
`define SBCH_ST_REENTRY      6'h1C
`define SBCH_ST_NO_IMAGE     6'h1D
`define SBCH_ST_FLASH_FAIL   6'h20
`define SBCH_ST_BAD_PAGE     6'h21
`define SBCH_CMD_ERASE_SEC   8'h45
`define SBCH_CMD_ERASE_PAGE  8'h58
`define SBCH_CMD_BLANK       8'h49
`define SBCH_CMD_PART_ID     8'h4A
`define SBCH_CMD_BOOT_VER    8'h4B
`define SBCH_CMD_COMPARE     8'h4D
`define SBCH_CMD_SERIAL      8'h4E
`define SBCH_CMD_CRC         8'h53
`define SBCH_CRC_POLY        32'h04C11DB7
`define SBCH_CRC_SEED        32'hFFFFFFFF
`define SBCH_BOOT_PAGE_LO    16'h00FE
`define SBCH_BOOT_PAGE_HI    16'h00FF
`define SBCH_BOOT_SECTOR     16'h000F
`define SBCH_PAGES_PER_SEC   16'h0100
`define SBCH_ERASED_WORD     32'h00000000
`define SBCH_WORD_MASK       32'h00000003
`endif

// *** rtl/sbch_handler.v ***
// serial boot command handler: decoded command in, status and data words out
`timescale 1ns/1ps
`include "sbch_regs.vh"
module sbch_handler #(
	parameter SECTORS = 16, // number of flash sectors
	parameter MEM_WORDS_LOG2 = 16, // log2 of words in the mapped memory
	parameter [31:0] PART_ID = 32'h0000ABCD, // arbitrary identification value
	parameter [15:0] BOOT_VER = 16'h0D01, // major in upper byte, minor in lower
	parameter [127:0] SERIAL = 128'h0 // arbitrary serial number, word 0 lowest
) (
	input wire clk_i, // 10 MHz clock
	input wire rstn_i, // asynchronous reset, active low
	input wire cmd_valid_i, // one-cycle pulse: parsed command line
	input wire [7:0] cmd_code_i, // command letter in ASCII
	input wire [2:0] cmd_argc_i, // number of arguments given
	input wire [31:0] arg0_i, // first argument
	input wire [31:0] arg1_i, // second argument
	input wire [31:0] arg2_i, // third argument
	input wire unlocked_i, // unlock key has been accepted
	input wire guard_i, // readout guard active
	input wire [15:0] prepared_i, // sectors armed by prepare, one bit each
	input wire [31:0] mem_rdata_i, // memory word, one cycle after mem_req_o
	output reg busy_o, // command in progress
	output reg mem_req_o, // memory read request pulse
	output reg [31:0] mem_addr_o, // word address of memory read
	output reg erase_o, // one-cycle erase pulse
	output reg erase_page_o, // erase is by page, not sector
	output reg [15:0] erase_first_o, // first sector or page to erase
	output reg [15:0] erase_last_o, // last sector or page to erase
	output reg reprotect_o, // pulse: drop prepare on erased sectors
	output reg resp_valid_o, // one-cycle pulse: answer ready
	output reg [5:0] resp_status_o, // status code, sent as decimal line
	output reg [2:0] resp_words_o, // number of data words that follow
	output reg [127:0] resp_data_o // data words, word 0 in low bits
);
	localparam S_IDLE = 4'b0001; // waiting for a command
	localparam S_READ = 4'b0010; // memory read issued
	localparam S_USE = 4'b0100; // data word arrives
	localparam S_DONE = 4'b1000; // answer goes out
	localparam [31:0] MEM_WORDS = 32'h1 << MEM_WORDS_LOG2; // words in map
	localparam [31:0] SEC_WORDS = MEM_WORDS / SECTORS; // words per sector

	reg [3:0] state_reg; // one-hot state
	reg [7:0] op_reg; // command being run
	reg [31:0] ptr_a_reg; // first address (word)
	reg [31:0] ptr_b_reg; // second address (word)
	reg [31:0] left_reg; // words remaining
	reg [31:0] off_reg; // byte offset walked so far
	reg [31:0] hold_reg; // word from region a, held for compare
	reg phase_reg; // compare: 0 reading a, 1 reading b
	reg [31:0] crc_reg; // running checksum

	// one CRC-32 step over a 32-bit word, msb first, no reflection
	function [31:0] crc_word;
		input [31:0] c;
		input [31:0] d;
		integer i;
		reg [31:0] r;
		begin
			r = c ^ d;
			for (i = 0; i < 32; i = i + 1) begin
				r = r[31] ? ((r << 1) ^ `SBCH_CRC_POLY) : (r << 1);
			end
			crc_word = r;
		end
	endfunction

	// a byte region is mapped when its last byte stays below the map end
	function mapped;
		input [31:0] addr;
		input [31:0] bytes;
		reg [33:0] end_b;
		begin
			end_b = {2'b00, addr} + {2'b00, bytes};
			mapped = (end_b <= {MEM_WORDS, 2'b00});
		end
	endfunction

	// sector range check, shared by sector erase and blank check
	function range_ok;
		input [31:0] a;
		input [31:0] b;
		begin
			range_ok = (b >= a) && (b < SECTORS);
		end
	endfunction

	// every sector in range must be armed by prepare
	function prep_ok;
		input [31:0] a;
		input [31:0] b;
		input [15:0] p;
		integer i;
		begin
			prep_ok = 1'b1;
			for (i = 0; i < 16; i = i + 1) begin
				if (i >= a && i <= b && !p[i]) begin
					prep_ok = 1'b0;
				end
			end
		end
	endfunction

	wire [31:0] last_page = SECTORS * `SBCH_PAGES_PER_SEC - 1; // highest page
	wire [31:0] boot_lo = `SBCH_BOOT_SECTOR * `SBCH_PAGES_PER_SEC + `SBCH_BOOT_PAGE_LO;
	wire [31:0] psec_a = arg0_i / `SBCH_PAGES_PER_SEC; // sector of first page
	wire [31:0] psec_b = arg1_i / `SBCH_PAGES_PER_SEC; // sector of last page

	// command intake, memory walk and answer, one process for all state
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_reg <= S_IDLE;
			op_reg <= 8'h00;
			ptr_a_reg <= 32'h0;
			ptr_b_reg <= 32'h0;
			left_reg <= 32'h0;
			off_reg <= 32'h0;
			hold_reg <= 32'h0;
			phase_reg <= 1'b0;
			crc_reg <= `SBCH_CRC_SEED;
			busy_o <= 1'b0;
			mem_req_o <= 1'b0;
			mem_addr_o <= 32'h0;
			erase_o <= 1'b0;
			erase_page_o <= 1'b0;
			erase_first_o <= 16'h0;
			erase_last_o <= 16'h0;
			reprotect_o <= 1'b0;
			resp_valid_o <= 1'b0;
			resp_status_o <= `SBCH_ST_SUCCESS;
			resp_words_o <= 3'h0;
			resp_data_o <= 128'h0;
		end else begin
			// pulses default low
			mem_req_o <= 1'b0;
			erase_o <= 1'b0;
			reprotect_o <= 1'b0;
			resp_valid_o <= 1'b0;
			case (state_reg)
			S_IDLE: begin
				if (cmd_valid_i) begin
					op_reg <= cmd_code_i;
					resp_words_o <= 3'h0;
					resp_data_o <= 128'h0;
					resp_status_o <= `SBCH_ST_SUCCESS;
					busy_o <= 1'b1;
					state_reg <= S_DONE; // most commands answer at once
					off_reg <= 32'h0;
					phase_reg <= 1'b0;
					crc_reg <= `SBCH_CRC_SEED;
					case (cmd_code_i)
					`SBCH_CMD_ERASE_SEC: begin
						if (cmd_argc_i < 3'd2) begin
							resp_status_o <= `SBCH_ST_PARAM;
						end else if (!unlocked_i) begin
							resp_status_o <= `SBCH_ST_LOCKED;
						end else if (!range_ok(arg0_i, arg1_i)) begin
							resp_status_o <= `SBCH_ST_BAD_RANGE;
						end else if (guard_i && (arg0_i != 0 || arg1_i != SECTORS - 1)) begin
							resp_status_o <= `SBCH_ST_GUARDED;
						end else if (!prep_ok(arg0_i, arg1_i, prepared_i)) begin
							resp_status_o <= `SBCH_ST_NOT_PREP;
						end else begin
							erase_o <= 1'b1;
							erase_page_o <= 1'b0;
							erase_first_o <= arg0_i[15:0];
							erase_last_o <= arg1_i[15:0];
							reprotect_o <= 1'b1;
						end
					end
					`SBCH_CMD_ERASE_PAGE: begin
						if (cmd_argc_i < 3'd2) begin
							resp_status_o <= `SBCH_ST_PARAM;
						end else if (!unlocked_i) begin
							resp_status_o <= `SBCH_ST_LOCKED;
						end else if (arg1_i < arg0_i || arg1_i > last_page
								|| arg1_i >= boot_lo) begin
							resp_status_o <= `SBCH_ST_BAD_PAGE;
						end else if (guard_i && (arg0_i != 0 || arg1_i != boot_lo - 1)) begin
							resp_status_o <= `SBCH_ST_GUARDED;
						end else if (!prep_ok(psec_a, psec_b, prepared_i)) begin
							resp_status_o <= `SBCH_ST_NOT_PREP;
						end else begin
							erase_o <= 1'b1;
							erase_page_o <= 1'b1;
							erase_first_o <= arg0_i[15:0];
							erase_last_o <= arg1_i[15:0];
							reprotect_o <= 1'b1;
						end
					end
					`SBCH_CMD_BLANK: begin
						if (cmd_argc_i < 3'd2) begin
							resp_status_o <= `SBCH_ST_PARAM;
						end else if (guard_i) begin
							resp_status_o <= `SBCH_ST_GUARDED;
						end else if (!range_ok(arg0_i, arg1_i)) begin
							resp_status_o <= `SBCH_ST_BAD_RANGE;
						end else begin
							ptr_a_reg <= arg0_i * SEC_WORDS;
							left_reg <= (arg1_i - arg0_i + 1) * SEC_WORDS;
							mem_req_o <= 1'b1;
							mem_addr_o <= arg0_i * SEC_WORDS;
							state_reg <= S_READ;
						end
					end
					`SBCH_CMD_PART_ID: begin
						resp_words_o <= 3'h1;
						resp_data_o <= {96'h0, PART_ID};
					end
					`SBCH_CMD_BOOT_VER: begin
						resp_words_o <= 3'h2;
						resp_data_o <= {64'h0, 24'h0, BOOT_VER[7:0],
							24'h0, BOOT_VER[15:8]};
					end
					`SBCH_CMD_SERIAL: begin
						resp_words_o <= 3'h4;
						resp_data_o <= SERIAL;
					end
					`SBCH_CMD_COMPARE, `SBCH_CMD_CRC: begin
						if (cmd_argc_i < ((cmd_code_i == `SBCH_CMD_CRC) ? 3'd2 : 3'd3)) begin
							resp_status_o <= `SBCH_ST_PARAM;
						end else if (guard_i) begin
							resp_status_o <= `SBCH_ST_GUARDED;
						end else if (cmd_code_i == `SBCH_CMD_CRC) begin
							if ((arg0_i & `SBCH_WORD_MASK) != 0) begin
								resp_status_o <= `SBCH_ST_ADDR_MISAL;
							end else if ((arg1_i & `SBCH_WORD_MASK) != 0) begin
								resp_status_o <= `SBCH_ST_COUNT;
							end else if (!mapped(arg0_i, arg1_i)) begin
								resp_status_o <= `SBCH_ST_ADDR_UNMAP;
							end else if (arg1_i == 0) begin
								resp_words_o <= 3'h1;
								resp_data_o <= {96'h0, `SBCH_CRC_SEED};
							end else begin
								ptr_a_reg <= arg0_i >> 2;
								left_reg <= arg1_i >> 2;
								mem_req_o <= 1'b1;
								mem_addr_o <= arg0_i >> 2;
								state_reg <= S_READ;
							end
						end else if (((arg0_i | arg1_i) & `SBCH_WORD_MASK) != 0) begin
							resp_status_o <= `SBCH_ST_ADDR_MISAL;
						end else if ((arg2_i & `SBCH_WORD_MASK) != 0) begin
							resp_status_o <= `SBCH_ST_COUNT;
						end else if (!mapped(arg0_i, arg2_i) || !mapped(arg1_i, arg2_i)) begin
							resp_status_o <= `SBCH_ST_ADDR_UNMAP;
						end else if (arg2_i != 0) begin
							ptr_a_reg <= arg0_i >> 2;
							ptr_b_reg <= arg1_i >> 2;
							left_reg <= arg2_i >> 2;
							mem_req_o <= 1'b1;
							mem_addr_o <= arg0_i >> 2;
							state_reg <= S_READ;
						end
					end
					default: begin
						resp_status_o <= `SBCH_ST_INVALID_CMD;
					end
					endcase
				end
			end
			S_READ: begin
				state_reg <= S_USE; // read data valid next cycle
			end
			S_USE: begin
				state_reg <= S_READ; // another read unless a branch below ends the walk
				if (op_reg == `SBCH_CMD_COMPARE && !phase_reg) begin
					hold_reg <= mem_rdata_i; // region a word kept, count untouched
					phase_reg <= 1'b1;
					mem_req_o <= 1'b1;
					mem_addr_o <= ptr_b_reg;
				end else begin
					// one word finished: advance both pointers and the count together
					phase_reg <= 1'b0;
					off_reg <= off_reg + 32'h4;
					ptr_a_reg <= ptr_a_reg + 32'h1;
					ptr_b_reg <= ptr_b_reg + 32'h1;
					left_reg <= left_reg - 32'h1;
					crc_reg <= crc_word(crc_reg, mem_rdata_i);
					if (op_reg == `SBCH_CMD_BLANK && mem_rdata_i != `SBCH_ERASED_WORD) begin
						resp_status_o <= `SBCH_ST_NOT_BLANK;
						resp_words_o <= 3'h2;
						resp_data_o <= {64'h0, mem_rdata_i, off_reg};
						state_reg <= S_DONE;
					end else if (op_reg == `SBCH_CMD_COMPARE && hold_reg != mem_rdata_i) begin
						resp_status_o <= `SBCH_ST_MISMATCH;
						resp_words_o <= 3'h1;
						resp_data_o <= {96'h0, off_reg};
						state_reg <= S_DONE;
					end else if (left_reg == 32'h1) begin
						state_reg <= S_DONE; // walk complete, success stands
						if (op_reg == `SBCH_CMD_CRC) begin
							resp_words_o <= 3'h1;
							resp_data_o <= {96'h0, crc_word(crc_reg, mem_rdata_i)};
						end
					end else begin
						mem_req_o <= 1'b1;
						mem_addr_o <= ptr_a_reg + 32'h1;
					end
				end
			end
			S_DONE: begin
				resp_valid_o <= 1'b1;
				busy_o <= 1'b0;
				state_reg <= S_IDLE;
			end
			default: begin
				state_reg <= S_IDLE;
			end
			endcase
		end
	end
endmodule

// *** tb/sbch_chk.sv ***
// assertion checker for the serial boot command handler ports
`timescale 1ns/1ps
`include "sbch_regs.vh"
module sbch_chk #(
	parameter SECTORS = 16 // sector count handed on from the design
) (
	input wire clk_i, // clock
	input wire rstn_i, // reset, active low
	input wire cmd_valid_i, // command strobe
	input wire [7:0] cmd_code_i, // command letter
	input wire [2:0] cmd_argc_i, // argument count
	input wire [31:0] arg0_i, // first argument
	input wire [31:0] arg1_i, // second argument
	input wire unlocked_i, // unlock accepted
	input wire guard_i, // readout guard
	input wire [15:0] prepared_i, // armed sectors
	input wire busy_o, // busy
	input wire erase_o, // erase pulse
	input wire erase_page_o, // page erase
	input wire [15:0] erase_first_o, // first unit
	input wire [15:0] erase_last_o, // last unit
	input wire reprotect_o, // re-protect pulse
	input wire resp_valid_o, // answer strobe
	input wire [5:0] resp_status_o, // status
	input wire [2:0] resp_words_o // data word count
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	wire take = cmd_valid_i && !busy_o; // a command actually accepted
	property p_resp_pulse; resp_valid_o |=> !resp_valid_o; endproperty
	a_resp_pulse: assert property (p_resp_pulse) else $error("answer strobe too long");
	property p_part_id; take && cmd_code_i == `SBCH_CMD_PART_ID |-> ##2 resp_valid_o
		&& resp_status_o == `SBCH_ST_SUCCESS && resp_words_o == 3'h1; endproperty
	a_part_id: assert property (p_part_id) else $error("bad id answer");
	property p_boot_ver; take && cmd_code_i == `SBCH_CMD_BOOT_VER |-> ##2 resp_valid_o
		&& resp_status_o == `SBCH_ST_SUCCESS && resp_words_o == 3'h2; endproperty
	a_boot_ver: assert property (p_boot_ver) else $error("bad version answer");
	property p_serial; take && cmd_code_i == `SBCH_CMD_SERIAL |-> ##2 resp_valid_o
		&& resp_status_o == `SBCH_ST_SUCCESS && resp_words_o == 3'h4; endproperty
	a_serial: assert property (p_serial) else $error("bad serial answer");
	property p_unknown; take && cmd_code_i == 8'h5A |-> ##2 resp_valid_o
		&& resp_status_o == `SBCH_ST_INVALID_CMD; endproperty
	a_unknown: assert property (p_unknown) else $error("unknown letter not refused");
	property p_locked; take && cmd_code_i == `SBCH_CMD_ERASE_SEC && cmd_argc_i == 3'h2
		&& !unlocked_i |-> !erase_o ##[1:3] (resp_valid_o && resp_status_o == `SBCH_ST_LOCKED);
	endproperty
	a_locked: assert property (p_locked) else $error("locked erase went ahead");
	property p_reprotect; erase_o |-> reprotect_o; endproperty
	a_reprotect: assert property (p_reprotect) else $error("erase without re-protect");
	property p_order; erase_o |-> erase_first_o <= erase_last_o; endproperty
	a_order: assert property (p_order) else $error("erase range reversed");
	property p_boot_page; erase_o && erase_page_o |-> erase_last_o < 16'h0FFE; endproperty
	a_boot_page: assert property (p_boot_page) else $error("boot page erased");
	property p_prepared; erase_o && !erase_page_o |-> prepared_i[erase_first_o[3:0]]
		&& prepared_i[erase_last_o[3:0]]; endproperty
	a_prepared: assert property (p_prepared) else $error("unarmed sector erased");
	property p_guard_erase; erase_o && !erase_page_o && guard_i |-> erase_first_o == 16'h0
		&& erase_last_o == SECTORS - 1; endproperty
	a_guard_erase: assert property (p_guard_erase) else $error("partial guarded erase");
	property p_guard_crc; take && guard_i && cmd_code_i == `SBCH_CMD_CRC && cmd_argc_i == 3'h2
		&& arg0_i == 32'h0 && arg1_i == 32'h4 |-> ##[1:6] (resp_valid_o
		&& resp_status_o == `SBCH_ST_GUARDED); endproperty
	a_guard_crc: assert property (p_guard_crc) else $error("guarded checksum answered");
	property p_busy; take |=> busy_o; endproperty
	a_busy: assert property (p_busy) else $error("command taken without busy");
endmodule
bind sbch_handler sbch_chk #(.SECTORS(SECTORS)) chk (.clk_i(clk_i), .rstn_i(rstn_i),
	.cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i), .cmd_argc_i(cmd_argc_i),
	.arg0_i(arg0_i), .arg1_i(arg1_i), .unlocked_i(unlocked_i), .guard_i(guard_i),
	.prepared_i(prepared_i), .busy_o(busy_o), .erase_o(erase_o), .erase_page_o(erase_page_o),
	.erase_first_o(erase_first_o), .erase_last_o(erase_last_o), .reprotect_o(reprotect_o),
	.resp_valid_o(resp_valid_o), .resp_status_o(resp_status_o), .resp_words_o(resp_words_o));

// *** tb/sbch_mem_model.sv ***
// registered memory standing behind the handler's read port
`timescale 1ns/1ps
module sbch_mem_model (
	input wire clk_i, // clock
	input wire req_i, // read request
	input wire [31:0] addr_i, // word address
	output reg [31:0] rdata_o // word, one cycle after the request
);
	reg [31:0] words [0:15]; // preloaded by the bench; beyond reads erased
	integer i;
	initial begin
		for (i = 0; i < 16; i = i + 1) words[i] = 32'h0;
		rdata_o = 32'h0;
	end
	// idle cycles show inverted data so a stale sample never passes
	always @(posedge clk_i) begin
		if (req_i && addr_i < 32'h10) rdata_o <= words[addr_i[3:0]];
		else if (req_i) rdata_o <= 32'h0; // erased flash reads zero
		else rdata_o <= ~rdata_o;
	end
endmodule

// *** tb/tb.sv ***
// self-checking bench for the serial boot command handler
`timescale 1ns/1ps
`include "sbch_regs.vh"
module tb;
	reg clk_i = 0, rstn_i = 0, cmd_valid = 0, unlocked = 0, guard = 0;
	reg [7:0] code = 8'h00;
	reg [2:0] argc = 3'h0;
	reg [31:0] a0 = 0, a1 = 0, a2 = 0;
	reg [15:0] prep = 16'h0000;
	wire [31:0] rdata, maddr;
	wire busy, mreq, ers, epg, rprot, rv;
	wire [15:0] ef, el;
	wire [5:0] st;
	wire [2:0] nw;
	wire [127:0] rd;
	integer fail_count = 0, n_tests = 0, cyc = 0, ers_n = 0;
	reg [15:0] cap_f, cap_l; // last erase range seen
	reg cap_p = 0; // last erase was by page
	always #50 clk_i = ~clk_i;
	sbch_handler #(.PART_ID(32'h00001234), .BOOT_VER(16'h0203),
		.SERIAL(128'h44444444_33333333_22222222_11111111)) dut (.clk_i(clk_i), .rstn_i(rstn_i),
		.cmd_valid_i(cmd_valid), .cmd_code_i(code), .cmd_argc_i(argc), .arg0_i(a0),
		.arg1_i(a1), .arg2_i(a2), .unlocked_i(unlocked), .guard_i(guard), .prepared_i(prep),
		.mem_rdata_i(rdata), .busy_o(busy), .mem_req_o(mreq), .mem_addr_o(maddr),
		.erase_o(ers), .erase_page_o(epg), .erase_first_o(ef), .erase_last_o(el),
		.reprotect_o(rprot), .resp_valid_o(rv), .resp_status_o(st), .resp_words_o(nw),
		.resp_data_o(rd));
	sbch_mem_model mem (.clk_i(clk_i), .req_i(mreq), .addr_i(maddr), .rdata_o(rdata));
	// count erase pulses; the part id above is an arbitrary value
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (ers === 1'b1) begin
			ers_n <= ers_n + 1;
			cap_f <= ef;
			cap_l <= el;
			cap_p <= epg;
		end
		if (cyc == 20000) begin
			fail_count = fail_count + 1;
			conclude;
		end
	end
	task chk(input [63:0] nm, input [127:0] s, input [127:0] e);
		begin
			n_tests = n_tests + 1;
			if (s !== e) begin
				fail_count = fail_count + 1;
				$display("unexpected %0s exp %0h seen %0h", nm, e, s);
			end
		end
	endtask
	// one command line, held one edge, then wait for the answer strobe
	task run(input [7:0] c, input [2:0] n, input [31:0] x, input [31:0] y, input [31:0] z);
		integer k;
		reg got;
		begin
			got = 0;
			@(posedge clk_i);
			cmd_valid <= 1;
			code <= c;
			argc <= n;
			a0 <= x;
			a1 <= y;
			a2 <= z;
			@(posedge clk_i);
			cmd_valid <= 0;
			for (k = 0; k < 10000 && !got; k = k + 1) begin
				@(posedge clk_i);
				got = (rv === 1'b1);
			end
			chk("answer", got, 1);
		end
	endtask
	function [31:0] crc_w(input [31:0] d);
		integer i;
		reg [31:0] c;
		begin
			c = 32'hFFFFFFFF;
			for (i = 31; i >= 0; i = i - 1) c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? 32'h04C11DB7 : 0);
			crc_w = c;
		end
	endfunction
	task t_ident;
		begin
			run(`SBCH_CMD_PART_ID, 0, 0, 0, 0);
			chk("id", rd[31:0], 32'h00001234);
			run(`SBCH_CMD_BOOT_VER, 0, 0, 0, 0);
			chk("ver", rd[63:0], {32'h03, 32'h02});
			run(`SBCH_CMD_SERIAL, 0, 0, 0, 0);
			chk("serial", rd, 128'h44444444_33333333_22222222_11111111);
			run(8'h5A, 0, 0, 0, 0);
			chk("status", st, `SBCH_ST_INVALID_CMD);
			$display("test ident done");
		end
	endtask
	task t_erase;
		begin
			run(`SBCH_CMD_ERASE_SEC, 2, 2, 3, 0);
			chk("status", st, `SBCH_ST_LOCKED);
			unlocked <= 1;
			run(`SBCH_CMD_ERASE_SEC, 2, 2, 3, 0);
			chk("status", st, `SBCH_ST_NOT_PREP);
			chk("erases", ers_n, 0);
			prep <= 16'h000C;
			run(`SBCH_CMD_ERASE_SEC, 2, 2, 3, 0);
			chk("status", st, `SBCH_ST_SUCCESS);
			chk("range", {ers_n[7:0], cap_p, cap_f, cap_l}, {8'h1, 1'b0, 16'h2, 16'h3});
			run(`SBCH_CMD_ERASE_SEC, 2, 3, 2, 0);
			chk("status", st, `SBCH_ST_BAD_RANGE);
			prep <= 16'hFFFF;
			run(`SBCH_CMD_ERASE_PAGE, 2, 16'h0FFE, 16'h0FFF, 0);
			chk("status", st, `SBCH_ST_BAD_PAGE);
			run(`SBCH_CMD_ERASE_PAGE, 2, 2, 3, 0);
			chk("range", {ers_n[7:0], cap_p, cap_f, cap_l}, {8'h2, 1'b1, 16'h2, 16'h3});
			$display("test erase done");
		end
	endtask
	task t_guard;
		begin
			guard <= 1;
			run(`SBCH_CMD_ERASE_SEC, 2, 2, 3, 0);
			chk("refused", st == `SBCH_ST_SUCCESS || ers_n != 2, 0);
			run(`SBCH_CMD_ERASE_SEC, 2, 0, 15, 0);
			chk("range", {ers_n[7:0], cap_p, cap_f, cap_l}, {8'h3, 1'b0, 16'h0, 16'hF});
			run(`SBCH_CMD_CRC, 2, 0, 4, 0);
			chk("status", st, `SBCH_ST_GUARDED);
			guard <= 0;
			$display("test guard done");
		end
	endtask
	task t_mem;
		begin
			mem.words[0] = 32'h1;
			mem.words[1] = 32'h2;
			mem.words[4] = 32'h1;
			mem.words[5] = 32'h3;
			run(`SBCH_CMD_CRC, 2, 0, 4, 0);
			chk("crc", {st, rd[31:0]}, {`SBCH_ST_SUCCESS, crc_w(32'h1)});
			run(`SBCH_CMD_CRC, 2, 0, 3, 0);
			chk("status", st, `SBCH_ST_COUNT);
			run(`SBCH_CMD_CRC, 2, 2, 4, 0);
			chk("status", st, `SBCH_ST_ADDR_MISAL);
			run(`SBCH_CMD_COMPARE, 3, 0, 16, 4);
			chk("status", st, `SBCH_ST_SUCCESS);
			run(`SBCH_CMD_COMPARE, 3, 0, 16, 8);
			chk("cmp", {st, rd[31:0]}, {`SBCH_ST_MISMATCH, 32'h4});
			run(`SBCH_CMD_BLANK, 2, 0, 0, 0);
			chk("blank", {st, rd[63:0]}, {`SBCH_ST_NOT_BLANK, 32'h1, 32'h0});
			run(`SBCH_CMD_BLANK, 2, 1, 1, 0);
			chk("blank", {st, nw}, {`SBCH_ST_SUCCESS, 3'h0});
			$display("test memory done");
		end
	endtask
	task conclude;
		begin
			$display("checks %0d mismatches %0d", n_tests, fail_count);
			if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
			else $display("RESULT: FAIL");
			$finish;
		end
	endtask
	initial begin
		repeat (5) @(posedge clk_i);
		rstn_i <= 1;
		t_ident;
		t_erase;
		t_guard;
		t_mem;
		conclude;
	end
endmodule
